// File: shared/aoc_pkg.sv
package aoc_pkg;

  // Channels and data layout
  localparam int          NCH          = 2;
  localparam int          DW           = 12;
  localparam int          ACR_W        = 10;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          FIFO_AW      = 2;
  localparam int          TAG_LSB      = 12;

  // Conversion timing, in conversion-clock periods and peripheral clocks
  localparam int          CLK_DIV      = 2;
  localparam logic [4:0]  CONV_PERIODS = 5'h19;
  localparam int          EOC_LATE     = 2;

  // Start-up code to peripheral clock periods
  localparam logic [11:0] SU_STEP_LO   = 12'h008;
  localparam logic [11:0] SU_BASE_MID  = 12'h040;
  localparam logic [11:0] SU_STEP_MID  = 12'h010;
  localparam logic [11:0] SU_BASE_HI   = 12'h200;
  localparam logic [11:0] SU_STEP_HI   = 12'h040;
  localparam logic [5:0]  SU_CODE_MID  = 6'h04;
  localparam logic [5:0]  SU_CODE_HI   = 6'h08;

  // Register offsets reported on a protection violation
  localparam logic [7:0]  OFF_MR       = 8'h04;
  localparam logic [7:0]  OFF_CHER     = 8'h10;
  localparam logic [7:0]  OFF_CHDR     = 8'h14;
  localparam logic [7:0]  OFF_ACR      = 8'h94;

  // Trigger source codes
  localparam logic [2:0]  TRG_PIN      = 3'h0;
  localparam logic [2:0]  TRG_RESERVED = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_STARTUP = 3'h1,
    ST_WAIT    = 3'h3,
    ST_CONVERT = 3'h2,
    ST_SETTLE  = 3'h6
  } aoc_state_e;

endpackage

// File: rtl/aoc_fifo.sv
module aoc_fifo
  import aoc_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 4,
  parameter int AW    = 2
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          rstn,
  // Fill side
  input  wire logic          push,
  input  wire logic [W-1:0]  push_data,
  // Drain side
  input  wire logic          pop,
  output logic      [W-1:0]  pop_data,
  // Level
  output logic      [AW:0]   count,
  output logic               full,
  output logic               empty
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } aoc_fifo_s;

  aoc_fifo_s s;
  aoc_fifo_s next_s;
  logic      do_push;
  logic      do_pop;

  assign full     = (s.cnt == (AW+1)'(DEPTH));
  assign empty    = (s.cnt == '0);
  assign count    = s.cnt;
  assign pop_data = s.mem[s.rd];

  // Pointers wrap naturally, so DEPTH must be a power of two
  always_comb begin
    next_s  = s;
    do_push = push & ~full;
    do_pop  = pop & ~empty;
    if (do_push) begin
      next_s.mem[s.wr] = push_data;
      next_s.wr        = s.wr + AW'(1);
    end
    if (do_pop) begin
      next_s.rd = s.rd + AW'(1);
    end
    next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // aoc_fifo

// File: rtl/aoc_analog_output_controller.sv
module aoc_analog_output_controller
  import aoc_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Mode register write
  input  wire logic                 mode_wr,
  input  wire logic                 mode_trigger_enable,
  input  wire logic [2:0]           mode_trigger_source_select,
  input  wire logic                 mode_word,
  input  wire logic [1:0]           mode_user_sel,
  input  wire logic                 mode_tag,
  input  wire logic                 mode_max_speed_mode,
  input  wire logic [5:0]           mode_startup,
  // Channel enable and disable
  input  wire logic                 chan_enable_wr,
  input  wire logic                 chan_disable_wr,
  input  wire logic [NCH-1:0]       chan_mask,
  // Analog current
  input  wire logic                 acr_wr,
  input  wire logic [ACR_W-1:0]     acr_wdata,
  // Conversion data
  input  wire logic                 cdr_wr,
  input  wire logic [31:0]          cdr_wdata,
  // Status reads
  input  wire logic                 isr_rd,
  input  wire logic                 wpsr_rd,
  // Protection and interrupt masks
  input  wire logic                 write_protect_enable,
  input  wire logic                 eoc_irq_en,
  input  wire logic                 transmit_ready_flag_irq_en,
  // Trigger sources
  input  wire logic                 external_trigger_pin,
  input  wire logic [2:0]           tio_trig,
  input  wire logic [1:0]           pwm_event,
  // Outputs
  output logic [NCH-1:0][DW-1:0]    analog_output_lines,
  output logic [NCH-1:0]            chan_status,
  output logic [ACR_W-1:0]          acr,
  output logic                      active,
  output logic                      transmit_ready_flag,
  output logic                      eoc,
  output logic                      protect_violation_flag,
  output logic [7:0]                protect_violation_source,
  output logic                      irq
);

  typedef struct packed {
    aoc_state_e               st;
    logic                     div;
    logic [11:0]              cnt;
    logic [5:0]               conv_cyc;
    logic [EOC_LATE-1:0]      eoc_pipe;
    logic                     pend;
    logic [15:0]              pend_data;
    logic [15:0]              item;
    logic                     s1;
    logic                     s2;
    logic                     s3;
    logic                     lvl;
    logic [2:0]               tio_prev;
    logic [1:0]               pwm_prev;
    logic                     trigger_enable;
    logic [2:0]               trigger_source_select;
    logic                     word;
    logic [1:0]               user_sel;
    logic                     tag;
    logic                     max_speed_mode;
    logic [5:0]               startup;
    logic [NCH-1:0]           chan_en;
    logic [ACR_W-1:0]         acr;
    logic [NCH-1:0][DW-1:0]   out;
    logic                     eoc;
    logic                     tx_ready;
    logic                     wp_flag;
    logic [7:0]               wp_src;
    logic                     irq;
    logic                     active;
  } aoc_state_s;

  aoc_state_s          s;
  aoc_state_s          next_s;
  logic                dac_en;
  logic [7:0]          rise;
  logic                trig_rise;
  logic                prot_wr;
  logic                viol;
  logic                push;
  logic [15:0]         push_data;
  logic                pop;
  logic                out_wr;
  logic [1:0]          sel;
  logic [FIFO_AW:0]    next_count;
  logic [FIFO_AW:0]    free;
  logic [FIFO_AW:0]    need;
  logic [15:0]         fifo_data;
  logic [FIFO_AW:0]    fifo_count;
  logic                fifo_full;
  logic                fifo_empty;

  function automatic logic [11:0] startup_cycles(input logic [5:0] code);
    logic [11:0] ext;
    ext = {6'h00, code};
    if (code < SU_CODE_MID) begin
      startup_cycles = ext * SU_STEP_LO;
    end else if (code < SU_CODE_HI) begin
      startup_cycles = SU_BASE_MID + (ext - 12'(SU_CODE_MID)) * SU_STEP_MID;
    end else begin
      startup_cycles = SU_BASE_HI + (ext - 12'(SU_CODE_HI)) * SU_STEP_HI;
    end
  endfunction

  aoc_fifo #(
    .W     (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) aoc_fifo_inst (
    .mclk      (mclk),
    .rstn      (rstn),
    .push      (push),
    .push_data (push_data),
    .pop       (pop),
    .pop_data  (fifo_data),
    .count     (fifo_count),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  always_comb begin
    next_s = s;
    // Divide by two: one enable every other peripheral clock
    dac_en     = s.div;
    next_s.div = ~s.div;

    // Pin trigger: a rising change counts once the second and third stages agree
    next_s.s1 = external_trigger_pin;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.lvl = s.s3;
    end
    rise[0]         = (s.s2 == s.s3) & s.s3 & ~s.lvl;
    rise[3:1]       = tio_trig & ~s.tio_prev;
    rise[5:4]       = pwm_event & ~s.pwm_prev;
    rise[7:6]       = 2'h0;
    next_s.tio_prev = tio_trig;
    next_s.pwm_prev = pwm_event;
    // Reserved codes never fire
    trig_rise = rise[s.trigger_source_select];

    // Write protection
    prot_wr = mode_wr | chan_enable_wr | chan_disable_wr | acr_wr;
    viol    = write_protect_enable & prot_wr;
    if (viol) begin
      next_s.wp_flag = 1'b1;
      if (mode_wr) begin
        next_s.wp_src = OFF_MR;
      end else if (chan_enable_wr) begin
        next_s.wp_src = OFF_CHER;
      end else if (chan_disable_wr) begin
        next_s.wp_src = OFF_CHDR;
      end else begin
        next_s.wp_src = OFF_ACR;
      end
    end else if (wpsr_rd) begin
      next_s.wp_flag = 1'b0;
    end
    if (!write_protect_enable) begin
      if (mode_wr) begin
        next_s.trigger_enable    = mode_trigger_enable;
        next_s.trigger_source_select   = mode_trigger_source_select;
        next_s.word     = mode_word;
        next_s.user_sel = mode_user_sel;
        next_s.tag      = mode_tag;
        next_s.max_speed_mode     = mode_max_speed_mode;
        next_s.startup  = mode_startup;
      end
      if (chan_enable_wr) begin
        next_s.chan_en = next_s.chan_en | chan_mask;
      end
      // Disable wins when both strike the same channel
      if (chan_disable_wr) begin
        next_s.chan_en = next_s.chan_en & ~chan_mask;
      end
      if (acr_wr) begin
        next_s.acr = acr_wdata;
      end
    end

    // Data entry: a word write parks its high half for one cycle
    push        = s.pend | (cdr_wr & ~s.pend);
    push_data   = s.pend ? s.pend_data : cdr_wdata[15:0];
    next_s.pend = 1'b0;
    if (cdr_wr && !s.pend && s.word) begin
      next_s.pend      = 1'b1;
      next_s.pend_data = cdr_wdata[31:16];
    end

    // Conversion engine
    pop             = 1'b0;
    out_wr          = 1'b0;
    sel             = s.tag ? s.item[TAG_LSB+1:TAG_LSB] : s.user_sel;
    next_s.eoc_pipe = {s.eoc_pipe[EOC_LATE-2:0], 1'b0};
    if (s.st == ST_CONVERT) begin
      next_s.conv_cyc = s.conv_cyc + 6'h01;
    end
    unique case (s.st)
      ST_IDLE: begin
        if (s.chan_en != '0 && !fifo_empty) begin
          next_s.st     = ST_STARTUP;
          next_s.cnt    = startup_cycles(s.startup);
          next_s.active = 1'b1;
        end
      end
      ST_STARTUP: begin
        if (s.cnt == '0) begin
          next_s.st = ST_WAIT;
        end else begin
          next_s.cnt = s.cnt - 12'h001;
        end
      end
      ST_WAIT: begin
        // Trigger enable is read live, so clearing it releases a waiting item
        if (s.chan_en != '0 && !fifo_empty && (!s.trigger_enable || trig_rise)) begin
          pop             = 1'b1;
          next_s.item     = fifo_data;
          next_s.cnt      = '0;
          next_s.conv_cyc = '0;
          next_s.st       = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (dac_en) begin
          if (s.cnt == 12'(CONV_PERIODS - 5'h01)) begin
            out_wr             = 1'b1;
            next_s.eoc_pipe[0] = 1'b1;
            // Max speed skips the end-of-cycle wait
            next_s.st          = s.max_speed_mode ? ST_WAIT : ST_SETTLE;
          end else begin
            next_s.cnt = s.cnt + 12'h001;
          end
        end
      end
      ST_SETTLE: begin
        if (s.eoc_pipe[EOC_LATE-1]) begin
          next_s.st = ST_WAIT;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // Tag codes beyond the channel count convert but drive nothing
    if (out_wr && sel < 2'(NCH)) begin
      next_s.out[sel[0]] = s.item[DW-1:0];
    end
    if (s.chan_en == '0) begin
      next_s.st     = ST_IDLE;
      next_s.active = 1'b0;
    end

    // End of conversion: set wins over the clearing read
    if (s.eoc_pipe[EOC_LATE-1]) begin
      next_s.eoc = 1'b1;
    end else if (isr_rd) begin
      next_s.eoc = 1'b0;
    end

    // Ready is registered from next occupancy so it never lags a fill
    next_count = fifo_count + (FIFO_AW+1)'(push & ~fifo_full) - (FIFO_AW+1)'(pop);
    free       = (FIFO_AW+1)'(FIFO_DEPTH) - next_count;
    need       = next_s.word ? (FIFO_AW+1)'(2) : (FIFO_AW+1)'(1);
    next_s.tx_ready = !next_s.pend && next_s.chan_en != '0 && free >= need;
    next_s.irq = (next_s.eoc & eoc_irq_en) | (next_s.tx_ready & transmit_ready_flag_irq_en);
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign analog_output_lines      = s.out;
  assign chan_status              = s.chan_en;
  assign acr                      = s.acr;
  assign active                   = s.active;
  assign transmit_ready_flag      = s.tx_ready;
  assign eoc                      = s.eoc;
  assign protect_violation_flag   = s.wp_flag;
  assign protect_violation_source = s.wp_src;
  assign irq                      = s.irq;

  a_conv_length: assert property (@(posedge mclk) disable iff (!rstn)
    out_wr |-> (s.conv_cyc == 6'd48 || s.conv_cyc == 6'd49))
    else $error("conversion length not 25 conversion periods");

  a_eoc_follows: assert property (@(posedge mclk) disable iff (!rstn)
    out_wr |-> ##3 s.eoc)
    else $error("end flag missing after conversion");

  a_eoc_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (isr_rd && !s.eoc_pipe[1]) |=> !s.eoc)
    else $error("status read did not clear end flag");

  a_idle_no_chan: assert property (@(posedge mclk) disable iff (!rstn)
    (s.chan_en == '0) |=> (s.st == ST_IDLE && !s.active))
    else $error("controller active with no channel");

  a_free_start: assert property (@(posedge mclk) disable iff (!rstn)
    (s.st == ST_WAIT && !s.trigger_enable && !fifo_empty && s.chan_en != '0) |=> s.st == ST_CONVERT)
    else $error("free-running conversion did not start");

  a_trig_wait: assert property (@(posedge mclk) disable iff (!rstn)
    (s.st == ST_WAIT && s.trigger_enable && !trig_rise) |=> s.st != ST_CONVERT)
    else $error("conversion started without trigger edge");

  a_ready_full: assert property (@(posedge mclk) disable iff (!rstn)
    (fifo_full || s.pend) |-> !s.tx_ready)
    else $error("ready flag high while unable to accept");

  a_half_push: assert property (@(posedge mclk) disable iff (!rstn)
    (cdr_wr && !s.word && s.tx_ready) |-> (push && push_data == cdr_wdata[15:0]) ##1 !s.pend)
    else $error("half-word write pushed wrong data");

  a_word_push: assert property (@(posedge mclk) disable iff (!rstn)
    (cdr_wr && s.word && s.tx_ready) |=> (push && push_data == $past(cdr_wdata[31:16])))
    else $error("word write high half not pushed next");

  a_wp_block: assert property (@(posedge mclk) disable iff (!rstn)
    (write_protect_enable && mode_wr) |=>
      (s.wp_flag && s.wp_src == OFF_MR && s.trigger_enable == $past(s.trigger_enable)))
    else $error("protected mode write not blocked");

  a_wp_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (wpsr_rd && !viol) |=> !s.wp_flag)
    else $error("violation flag not cleared by read");

  c_word_write: cover property (@(posedge mclk) disable iff (!rstn)
    cdr_wr && s.word && s.tx_ready);
  c_trig_conv: cover property (@(posedge mclk) disable iff (!rstn)
    s.st == ST_WAIT && s.trigger_enable && pop);
  c_max_speed: cover property (@(posedge mclk) disable iff (!rstn)
    out_wr && s.max_speed_mode ##1 pop);
  c_violation: cover property (@(posedge mclk) disable iff (!rstn)
    viol && wpsr_rd);

endmodule // aoc_analog_output_controller

// File: verification/aoc_trig_model.sv
module aoc_trig_model
  import aoc_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Request
  input  wire logic       fire,
  input  wire logic [2:0] code,
  // Trigger lines
  output logic            external_trigger_pin,
  output logic [2:0]      tio_trig,
  output logic [1:0]      pwm_event
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] hold = 4'h0;
  logic [7:0] lines;

  // Eight clocks high, long enough for the pin synchroniser
  always @(posedge mclk) begin
    if (fire) begin
      hold <= 4'h8;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end

  // Codes 6 and 7 reach no line
  assign lines                = (hold != 4'h0) ? (8'h01 << code) : 8'h00;
  assign external_trigger_pin = lines[0];
  assign tio_trig             = lines[3:1];
  assign pwm_event            = lines[5:4];
endmodule // aoc_trig_model

// File: verification/tb_aoc_analog_output_controller.sv
module tb_aoc_analog_output_controller
  import aoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Stimulus
  logic                   mclk, rstn, mode_wr, mode_trigger_enable, mode_word, mode_tag;
  logic                   mode_max_speed_mode, chan_enable_wr, chan_disable_wr, acr_wr;
  logic                   cdr_wr, isr_rd, wpsr_rd, write_protect_enable, fire;
  logic                   eoc_irq_en, transmit_ready_flag_irq_en, external_trigger_pin;
  logic [2:0]             mode_trigger_source_select, trg_code, tio_trig;
  logic [1:0]             mode_user_sel, chan_mask, pwm_event;
  logic [5:0]             mode_startup;
  logic [ACR_W-1:0]       acr_wdata, acr;
  logic [31:0]            cdr_wdata;
  // Observed
  logic [NCH-1:0][DW-1:0] analog_output_lines;
  logic [NCH-1:0]         chan_status;
  logic                   active, transmit_ready_flag, eoc, protect_violation_flag, irq;
  logic [7:0]             protect_violation_source;
  int                     failures = 0;
  int                     comparisons = 0;

  aoc_analog_output_controller aoc_analog_output_controller_inst (
    .mclk, .rstn, .mode_wr, .mode_trigger_enable, .mode_trigger_source_select,
    .mode_word, .mode_user_sel, .mode_tag, .mode_max_speed_mode, .mode_startup,
    .chan_enable_wr, .chan_disable_wr, .chan_mask, .acr_wr, .acr_wdata, .cdr_wr,
    .cdr_wdata, .isr_rd, .wpsr_rd, .write_protect_enable, .eoc_irq_en, .transmit_ready_flag_irq_en,
    .external_trigger_pin, .tio_trig, .pwm_event, .analog_output_lines, .chan_status,
    .acr, .active, .transmit_ready_flag, .eoc, .protect_violation_flag,
    .protect_violation_source, .irq
  );

  aoc_trig_model aoc_trig_model_inst (
    .mclk, .fire, .code(trg_code), .external_trigger_pin, .tio_trig, .pwm_event
  );

  initial begin
    {mclk, rstn, mode_wr, mode_trigger_enable, mode_word, mode_tag} = '0;
    {mode_max_speed_mode, chan_enable_wr, chan_disable_wr, acr_wr, cdr_wr} = '0;
    {isr_rd, wpsr_rd, write_protect_enable, eoc_irq_en, transmit_ready_flag_irq_en, fire} = '0;
    {mode_trigger_source_select, trg_code, mode_user_sel, chan_mask} = '0;
    {mode_startup, acr_wdata, cdr_wdata} = '0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      failures++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic set_mode(input logic te, input logic [2:0] ts, input logic w,
                          input logic [1:0] us, input logic mx, input logic [5:0] su);
    @(posedge mclk);
    mode_wr <= 1'b1;
    {mode_trigger_enable, mode_trigger_source_select, mode_word} <= {te, ts, w};
    {mode_user_sel, mode_tag, mode_max_speed_mode, mode_startup} <= {us, w, mx, su};
    @(posedge mclk);
    mode_wr <= 1'b0;
  endtask

  // Disable all, program mode, then enable; start-up is only spent leaving idle
  task automatic restart(input logic te, input logic [2:0] ts, input logic w,
                         input logic [1:0] us, input logic mx, input logic [5:0] su);
    chan(1'b1, 2'b11);
    set_mode(te, ts, w, us, mx, su);
    chan(1'b0, 2'b11);
  endtask

  task automatic chan(input logic dis, input logic [1:0] m);
    @(posedge mclk);
    {chan_enable_wr, chan_disable_wr, chan_mask} <= {~dis, dis, m};
    @(posedge mclk);
    {chan_enable_wr, chan_disable_wr} <= 2'b00;
  endtask

  task automatic put(input logic [31:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    while (transmit_ready_flag !== 1'b1 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    chk("ready before write", 1'b1, transmit_ready_flag);
    @(posedge mclk);
    {cdr_wr, cdr_wdata} <= {1'b1, d};
    @(posedge mclk);
    cdr_wr <= 1'b0;
  endtask

  task automatic wait_out(input int ch, input logic [11:0] v, output int n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (analog_output_lines[ch] !== v && n < 2000);
    chk("output value", v, analog_output_lines[ch]);
  endtask

  task automatic t_free(input logic [1:0] us, input logic [5:0] su, input int suc,
                        input logic [11:0] v);
    int n;
    chan(1'b1, 2'b11);
    repeat (2) @(negedge mclk);
    chk("active", 1'b0, active);
    set_mode(1'b0, 3'h0, 1'b0, us, 1'b0, su);
    chan(1'b0, 2'b11);
    eoc_irq_en <= 1'b1;
    repeat (2) @(negedge mclk);
    chk("ready", 1'b1, transmit_ready_flag);
    put({16'h5a5a, 4'hf, v});
    wait_out(us, v, n);
    chk_rng("latency", 52 + suc, 54 + suc, n);
    chk("active", 1'b1, active);
    repeat (2) @(negedge mclk);
    chk("eoc", 1'b1, eoc);
    @(negedge mclk);
    chk("irq", 1'b1, irq);
    @(posedge mclk);
    {isr_rd, eoc_irq_en} <= 2'b10;
    @(posedge mclk);
    isr_rd <= 1'b0;
    @(negedge mclk);
    chk("eoc", 1'b0, eoc);
    chk("irq masked", 1'b0, irq);
    @(posedge mclk);
    transmit_ready_flag_irq_en <= 1'b1;
    @(posedge mclk);
    transmit_ready_flag_irq_en <= 1'b0;
    @(negedge mclk);
    chk("irq ready", 1'b1, irq);
    $display("free-running test done");
  endtask

  task automatic t_word;
    int n;
    restart(1'b0, 3'h0, 1'b1, 2'h0, 1'b0, 6'h00);
    put(32'h1123_0456);
    wait_out(0, 12'h456, n);
    wait_out(1, 12'h123, n);
    chk_rng("second item gap", 52, 53, n);
    $display("word test done");
  endtask

  // Start-up of 24 clocks holds the first pop until the fifo is full
  task automatic t_fill(input logic mx);
    int n;
    restart(1'b0, 3'h0, 1'b0, 2'h1, mx, 6'h03);
    for (int i = 0; i < FIFO_DEPTH; i++) put({20'h0, mx, 1'b1, 2'(i), 8'h3c});
    repeat (2) @(negedge mclk);
    chk("ready when full", 1'b0, transmit_ready_flag);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      wait_out(1, {mx, 1'b1, 2'(i), 8'h3c}, n);
      if (i == 2) chk_rng("pacing", mx ? 50 : 52, mx ? 51 : 53, n);
    end
    @(negedge mclk);
    chk("ready when drained", 1'b1, transmit_ready_flag);
    $display("fifo test done");
  endtask

  task automatic t_trig;
    int n;
    logic [11:0] v;
    logic [11:0] old;
    for (int c = 0; c < 7; c++) begin
      v = {4'h7, 5'(c), 3'h1};
      restart(1'b1, 3'(c), 1'b0, 2'h0, 1'b0, 6'h00);
      trg_code <= 3'(c);
      old = analog_output_lines[0];
      put({20'h0, v});
      repeat (80) @(negedge mclk);
      chk("held until trigger", old, analog_output_lines[0]);
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      if (c == 6) begin
        repeat (80) @(negedge mclk);
        chk("reserved source", old, analog_output_lines[0]);
        set_mode(1'b0, 3'h6, 1'b0, 2'h0, 1'b0, 6'h00);
      end
      wait_out(0, v, n);
      chk_rng("start after trigger", 1, 70, n);
    end
    $display("trigger test done");
  endtask

  task automatic t_prot;
    logic [7:0] off [4];
    off = '{OFF_MR, OFF_CHER, OFF_CHDR, OFF_ACR};
    chan(1'b1, 2'b10);
    @(posedge mclk);
    {acr_wr, acr_wdata} <= {1'b1, 10'h155};
    @(posedge mclk);
    {acr_wr, acr_wdata, write_protect_enable} <= {1'b0, 10'h2aa, 1'b1};
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      {mode_wr, chan_enable_wr, chan_disable_wr, acr_wr} <= 4'h8 >> k;
      chan_mask <= 2'b11;
      @(posedge mclk);
      {mode_wr, chan_enable_wr, chan_disable_wr, acr_wr} <= 4'h0;
      @(negedge mclk);
      chk("violation flag", 1'b1, protect_violation_flag);
      chk("violation source", off[k], protect_violation_source);
      chk("channels kept", 2'b01, chan_status);
      chk("current kept", 10'h155, acr);
      @(posedge mclk);
      wpsr_rd <= 1'b1;
      @(posedge mclk);
      wpsr_rd <= 1'b0;
      @(negedge mclk);
      chk("violation cleared", 1'b0, protect_violation_flag);
    end
    $display("protection test done");
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk("reset ready", 1'b0, transmit_ready_flag);
    chk("reset active", 1'b0, active);
    t_free(2'h0, 6'h00, 0, 12'habc);
    t_free(2'h1, 6'h01, 8, 12'h321);
    t_free(2'h0, 6'h04, 64, 12'h5e7);
    t_free(2'h1, 6'h08, 512, 12'h0f1);
    t_free(2'h0, 6'h05, 80, 12'h2d4);
    t_free(2'h1, 6'h09, 576, 12'h1b6);
    t_word();
    t_fill(1'b0);
    t_fill(1'b1);
    t_trig();
    t_prot();
    results();
  end

  // Whole run needs well under ten thousand clocks
  initial begin
    repeat (30000) @(posedge mclk);
    failures++;
    $display("Watchdog expired");
    results();
  end
endmodule // tb_aoc_analog_output_controller
